//--- logic/dual_slope_display_sequencer.sv
// Contract
// [R1] Decade counters advance once per four oscillator cycles.
// [R2] Phases run auto zero, signal integrate, reference integrate, output zero.
// [R3] Signal integrate lasts exactly 1000 counts, 4000 oscillator periods.
// [R4] Comparator sampled at end of signal integrate latches the sign.
// [R5] Reference polarity is opposite the latched input sign.
// [R6] Reference integrate counts from zero to crossing, at most 2000 counts.
// [R7] Auto zero takes the leftover count, between 300 and 2900.
// [R8] Output zero lasts 11 to 640 counts, set by reference span.
// [R9] Whole cycle always totals 4000 counts, 16000 oscillator pulses.
// [R10] Reference integrate count is the displayed reading, full scale 2000.
// [R11] Common plane is the oscillator divided by 800.
// [R12] Segment in phase with plane blanks, antiphase lights.
// [R13] Minus sign lit while latched sign is negative.
// [R14] Force input drives every segment and sign on statically.
// [R15] Hold keeps conversions running but freezes the display latch.
// [R16] Outside party holds hold input low for continuous updates.
// [R17] Output zero 11..140 in range, 31..640 after overrange.
// [R18] Auto zero 910.. in range, 300..910 after overrange.
// [R19] Three digits drive seven segments; thousands drives one pair output.
// [R20] No crossing by 2000 counts flags overrange, shows blanked leading one.
// [R21] Each unheld conversion end loads counters into latch, decoded.
module dual_slope_display_sequencer
  import dsds_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  comparatorOut,
  input  wire logic  hold_reading_input,
  input  wire logic  all_segments_force,
  output logic       autoZeroSwitch,
  output logic       signalSwitch,
  output logic       referenceSwitch,
  output logic       referencePositive,
  output logic       outputZeroSwitch,
  output logic [6:0] unitsSeg,
  output logic [6:0] tensSeg,
  output logic [6:0] hundredsSeg,
  output logic       thousands_one_pair,
  output logic       sign_segment_drive,
  output logic       common_plane_drive
);

  display_if disp ();

  logic [1:0]      compSync_r;
  logic [1:0]      holdSync_r;
  logic [1:0]      forceSync_r;
  logic [1:0]      divCnt_r;
  phase_e          phase_r;
  phase_e          phase_nxt;
  count_t          phaseCnt_r;
  count_t          azSpan_r;
  count_t          zeroSpan_r;
  logic            signNeg_r;
  logic [2:0][3:0] digit_r;
  logic            thou_r;
  logic [2:0][3:0] dispDigit_r;
  logic            dispThou_r;
  logic            dispNeg_r;
  logic            dispOver_r;
  logic            overFlag_r;
  plane_t          planeCnt_r;
  logic            plane_r;

  // Pins pass two flip-flops; only the second stage is read below
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compSync_r  <= 2'h0;
      holdSync_r  <= 2'h0;
      forceSync_r <= 2'h0;
    end else begin
      compSync_r  <= {compSync_r[0], comparatorOut};
      holdSync_r  <= {holdSync_r[0], hold_reading_input};   // [R16]
      forceSync_r <= {forceSync_r[0], all_segments_force};
    end
  end

  wire compNow  = compSync_r[1];
  wire holdNow  = holdSync_r[1];
  wire forceNow = forceSync_r[1];

  // Count enable: one pulse every four oscillator cycles
  wire countTick = (divCnt_r == OSC_DIV_LAST);                  // [R1]

  // Crossing: comparator leaves the level it had when sign was latched
  wire crossing  = (phase_r == PH_REF_INT) && (compNow != signNeg_r);
  wire refFull   = (phaseCnt_r == REF_MAX_COUNTS - 12'd1);      // [R6]
  wire azEnd     = (phaseCnt_r == azSpan_r - 12'd1);
  wire sigEnd    = (phaseCnt_r == SIG_COUNTS - 12'd1);          // [R3]
  wire zeroEnd   = (phaseCnt_r == zeroSpan_r - 12'd1);

  logic phaseEnd;
  always_comb begin
    case (phase_r)
      PH_AUTO_ZERO: phaseEnd = azEnd;                           // [R7]
      PH_SIG_INT:   phaseEnd = sigEnd;
      PH_REF_INT:   phaseEnd = crossing || refFull;
      PH_OUT_ZERO:  phaseEnd = zeroEnd;                         // [R8]
      default:      phaseEnd = 1'b1;
    endcase
  end

  wire advance = countTick && phaseEnd;

  // Fixed phase order, wrapping into the next conversion
  always_comb begin
    phase_nxt = phase_r;
    if (advance) begin
      case (phase_r)
        PH_AUTO_ZERO: phase_nxt = PH_SIG_INT;                   // [R2]
        PH_SIG_INT:   phase_nxt = PH_REF_INT;
        PH_REF_INT:   phase_nxt = PH_OUT_ZERO;
        PH_OUT_ZERO:  phase_nxt = PH_AUTO_ZERO;
        default:      phase_nxt = PH_AUTO_ZERO;
      endcase
    end
  end

  // Spans fixed when reference integrate ends; reference phase of length refLen
  wire    refOver = !crossing;                                  // [R20]
  count_t refLen;
  count_t zeroIn;
  count_t zeroSpanNew;
  count_t azSpanNew;
  assign refLen      = phaseCnt_r + 12'd1;
  assign zeroIn      = ZERO_IN_BASE - (refLen >> ZERO_SHIFT_A)
                       - (refLen >> ZERO_SHIFT_B);              // [R17]
  assign zeroSpanNew = refOver ? ZERO_OVER : zeroIn;            // [R17]
  // Leftover goes to auto zero so the cycle always sums to 4000
  assign azSpanNew   = CYCLE_COUNTS - SIG_COUNTS - refLen
                       - zeroSpanNew;                           // [R9] [R18]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r   <= 2'h0;
      phase_r    <= PH_AUTO_ZERO;
      phaseCnt_r <= 12'd0;
    end else begin
      divCnt_r   <= divCnt_r + 2'h1;
      phase_r    <= phase_nxt;
      if (advance)
        phaseCnt_r <= 12'd0;
      else if (countTick)
        phaseCnt_r <= phaseCnt_r + 12'd1;
    end
  end

  // Sign latch and span registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      signNeg_r  <= 1'b0;
      azSpan_r   <= AZ_RESET_COUNTS;
      zeroSpan_r <= ZERO_IN_BASE;
      overFlag_r <= 1'b0;
    end else if (advance) begin
      if (phase_r == PH_SIG_INT)
        signNeg_r <= compNow;                                   // [R4]
      if (phase_r == PH_REF_INT) begin
        zeroSpan_r <= zeroSpanNew;
        azSpan_r   <= azSpanNew;
        overFlag_r <= refOver;                                  // [R20]
      end
    end
  end

  // Decade counters run only while deintegrating, cleared on entry
  wire bcdClr = advance && (phase_r == PH_SIG_INT);
  wire bcdInc = countTick && (phase_r == PH_REF_INT) && !crossing;
  logic [3:0]      carry;
  logic [2:0][3:0] digit_nxt;
  assign carry[0] = bcdInc;                                     // [R10]

  // Next value per decade; one register process keeps a single driver
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_dec
      assign carry[i+1]   = carry[i] && (digit_r[i] == BCD_NINE);
      assign digit_nxt[i] = bcdClr    ? 4'h0 :
                            !carry[i] ? digit_r[i] :
                            (digit_r[i] == BCD_NINE) ? 4'h0
                                                     : digit_r[i] + 4'h1;
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      digit_r <= '0;
      thou_r  <= 1'b0;
    end else begin
      digit_r <= digit_nxt;
      if (bcdClr)
        thou_r <= 1'b0;
      else if (carry[3])
        thou_r <= 1'b1;
    end
  end

  // Display latch loads at conversion end unless held
  wire loadDisp = advance && (phase_r == PH_OUT_ZERO) && !holdNow; // [R15]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dispDigit_r <= '0;
      dispThou_r  <= 1'b0;
      dispNeg_r   <= 1'b0;
      dispOver_r  <= 1'b0;
    end else if (loadDisp) begin
      dispDigit_r <= digit_r;                                   // [R21]
      dispThou_r  <= thou_r;
      dispNeg_r   <= signNeg_r;                                 // [R13]
      dispOver_r  <= overFlag_r;
    end
  end

  // Plane square wave, half period 400 oscillator cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      planeCnt_r <= 9'd0;
      plane_r    <= 1'b0;
    end else if (planeCnt_r == PLANE_HALF_LAST) begin
      planeCnt_r <= 9'd0;
      plane_r    <= ~plane_r;                                   // [R11]
    end else begin
      planeCnt_r <= planeCnt_r + 9'd1;
    end
  end

  // Switch controls registered from the next phase, so they track phase_r
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      autoZeroSwitch    <= 1'b1;
      signalSwitch      <= 1'b0;
      referenceSwitch   <= 1'b0;
      outputZeroSwitch  <= 1'b0;
      referencePositive <= 1'b0;
    end else begin
      autoZeroSwitch    <= (phase_nxt == PH_AUTO_ZERO);
      signalSwitch      <= (phase_nxt == PH_SIG_INT);
      referenceSwitch   <= (phase_nxt == PH_REF_INT);
      outputZeroSwitch  <= (phase_nxt == PH_OUT_ZERO);
      // Sign settles at the end of signal integrate, on the edge the reference switch closes
      referencePositive <= (advance && phase_r == PH_SIG_INT) ? compNow
                                                              : signNeg_r; // [R5]
    end
  end

  assign disp.digit     = dispDigit_r;
  assign disp.thousand  = dispThou_r;
  assign disp.negative  = dispNeg_r;
  assign disp.overrange = dispOver_r;
  assign disp.plane     = plane_r;
  assign disp.allOn     = forceNow;

  display_driver u_display (
    .clk              (clk),
    .rstn             (rstn),
    .disp             (disp),
    .unitsSeg         (unitsSeg),
    .tensSeg          (tensSeg),
    .hundredsSeg      (hundredsSeg),
    .thousandsOnePair (thousands_one_pair),
    .signSegmentDrive (sign_segment_drive),
    .commonPlaneDrive (common_plane_drive)
  );

endmodule : dual_slope_display_sequencer

//--- shared/dsds_pkg.sv
package dsds_pkg;

  typedef logic [11:0] count_t;
  typedef logic [8:0]  plane_t;

  typedef enum logic [1:0] {
    PH_AUTO_ZERO,
    PH_SIG_INT,
    PH_REF_INT,
    PH_OUT_ZERO
  } phase_e;

  // Oscillator cycles per count, as the last value of a 2-bit divider
  localparam logic [1:0] OSC_DIV_LAST    = 2'h3;
  // Count lengths of the conversion
  localparam count_t     CYCLE_COUNTS    = 12'd4000;
  localparam count_t     SIG_COUNTS      = 12'd1000;
  localparam count_t     REF_MAX_COUNTS  = 12'd2000;
  localparam count_t     ZERO_IN_BASE    = 12'd140;
  localparam count_t     ZERO_OVER       = 12'd640;
  localparam count_t     AZ_RESET_COUNTS = 12'd2860;
  // Slope of the in-range output zero span against the return span
  localparam int         ZERO_SHIFT_A    = 5;
  localparam int         ZERO_SHIFT_B    = 6;
  // Common plane: oscillator divided by 800, toggled every 400 cycles
  localparam plane_t     PLANE_HALF_LAST = 9'd399;
  localparam logic [3:0] BCD_NINE        = 4'h9;

  // Digit to segments, bit order {g,f,e,d,c,b,a}
  function automatic logic [6:0] seven_seg(input logic [3:0] d);
    logic [6:0] s;
    s = 7'h00;
    case (d)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = 7'h00;
    endcase
    return s;
  endfunction : seven_seg

endpackage : dsds_pkg

//--- shared/display_if.sv
interface display_if;
  logic [2:0][3:0] digit;
  logic            thousand;
  logic            negative;
  logic            overrange;
  logic            plane;
  logic            allOn;

  modport source (
    output digit, thousand, negative, overrange, plane, allOn
  );
  modport sink (
    input  digit, thousand, negative, overrange, plane, allOn
  );
endinterface : display_if

//--- logic/display_driver.sv
module display_driver
  import dsds_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  display_if.sink    disp,
  output logic [6:0] unitsSeg,
  output logic [6:0] tensSeg,
  output logic [6:0] hundredsSeg,
  output logic       thousandsOnePair,
  output logic       signSegmentDrive,
  output logic       commonPlaneDrive
);

  logic [2:0][6:0] litSeg;
  logic [2:0][6:0] driveSeg;
  logic            thouDrive;
  logic            signDrive;

  // Lit pattern per digit; overrange blanks the lower digits
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_dig
      assign litSeg[i]   = disp.overrange ? 7'h00 :
                           seven_seg(disp.digit[i]);            // [R21] [R20]
      // Antiphase lights, in phase blanks; test mode is a static level
      assign driveSeg[i] = disp.allOn ? 7'h7f :                 // [R14]
                           ({7{disp.plane}} ^ litSeg[i]);       // [R12]
    end
  endgenerate

  assign thouDrive = disp.allOn ? 1'b1 :
                     (disp.plane ^ (disp.thousand | disp.overrange)); // [R19]
  assign signDrive = disp.allOn ? 1'b1 :
                     (disp.plane ^ disp.negative);              // [R13]

  // Plane and segments share one register stage so they stay aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unitsSeg         <= 7'h00;
      tensSeg          <= 7'h00;
      hundredsSeg      <= 7'h00;
      thousandsOnePair <= 1'b0;
      signSegmentDrive <= 1'b0;
      commonPlaneDrive <= 1'b0;
    end else begin
      unitsSeg         <= driveSeg[0];
      tensSeg          <= driveSeg[1];
      hundredsSeg      <= driveSeg[2];
      thousandsOnePair <= thouDrive;
      signSegmentDrive <= signDrive;
      commonPlaneDrive <= disp.plane;                           // [R11]
    end
  end

endmodule : display_driver

//--- testbench/dsds_properties.sv
module dsds_properties (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       all_segments_force,
  input wire logic       autoZeroSwitch,
  input wire logic       signalSwitch,
  input wire logic       referenceSwitch,
  input wire logic       outputZeroSwitch,
  input wire logic [6:0] unitsSeg,
  input wire logic [6:0] tensSeg,
  input wire logic [6:0] hundredsSeg,
  input wire logic       thousands_one_pair,
  input wire logic       sign_segment_drive,
  input wire logic       common_plane_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  ph;
  logic [15:0] phCnt_r;
  logic [15:0] cycCnt_r;
  logic [15:0] plCnt_r;
  logic        seen_r;

  // All four switches seen as one phase word
  assign ph = {autoZeroSwitch, signalSwitch, referenceSwitch,
               outputZeroSwitch};

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Clocks since last phase, conversion or plane change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phCnt_r  <= '0;
      cycCnt_r <= '0;
      plCnt_r  <= '0;
      seen_r   <= 1'b0;
    end else begin
      phCnt_r  <= $changed(ph) ? 16'h1 : phCnt_r + 16'h1;
      cycCnt_r <= $rose(signalSwitch) ? 16'h1 : cycCnt_r + 16'h1;
      plCnt_r  <= $changed(common_plane_drive) ? 16'h1 : plCnt_r + 16'h1;
      seen_r   <= seen_r | $rose(signalSwitch);
    end
  end

  chk_az_then_sig:
    assert property ($rose(signalSwitch) |-> $past(autoZeroSwitch))
      else $error("integrate did not follow auto zero");
  chk_sig_then_ref:
    assert property ($fell(signalSwitch) |-> referenceSwitch)
      else $error("reference did not follow integrate");
  chk_ref_then_zero:
    assert property ($fell(referenceSwitch) |-> outputZeroSwitch)
      else $error("output zero did not follow reference");
  chk_sig_span:
    assert property ($fell(signalSwitch) |-> phCnt_r == 16'd4000)
      else $error("integrate span wrong");
  chk_cycle_len:
    assert property ($rose(signalSwitch) && seen_r |-> cycCnt_r == 16'd16000)
      else $error("conversion length wrong");
  chk_ref_span:
    assert property ($fell(referenceSwitch) |->
                     phCnt_r <= 16'd8000 && phCnt_r[1:0] == 2'h0)
      else $error("reference span out of bounds");
  chk_zero_span:
    assert property ($fell(outputZeroSwitch) |->
                     phCnt_r inside {[16'd44:16'd2560]} && phCnt_r[1:0] == 2'h0)
      else $error("output zero span out of bounds");
  chk_az_span:
    assert property ($fell(autoZeroSwitch) |->
                     phCnt_r inside {[16'd1200:16'd11600]})
      else $error("auto zero span out of bounds");
  chk_force_on:
    assert property (all_segments_force [*5] |-> &{unitsSeg, tensSeg,
                     hundredsSeg, thousands_one_pair, sign_segment_drive})
      else $error("forced segments not all on");
  chk_plane_half:
    assert property ($changed(common_plane_drive) && seen_r |->
                     plCnt_r == 16'd400)
      else $error("plane half period wrong");
endmodule : dsds_properties

bind dual_slope_display_sequencer dsds_properties i_props (
  .clk                (clk),
  .rstn               (rstn),
  .all_segments_force (all_segments_force),
  .autoZeroSwitch     (autoZeroSwitch),
  .signalSwitch       (signalSwitch),
  .referenceSwitch    (referenceSwitch),
  .outputZeroSwitch   (outputZeroSwitch),
  .unitsSeg           (unitsSeg),
  .tensSeg            (tensSeg),
  .hundredsSeg        (hundredsSeg),
  .thousands_one_pair (thousands_one_pair),
  .sign_segment_drive (sign_segment_drive),
  .common_plane_drive (common_plane_drive)
);

//--- testbench/frontend_model.sv
module frontend_model (
  input  wire logic        clk,
  input  wire logic        signalSwitch,
  input  wire logic        referenceSwitch,
  input  wire logic        referencePositive,
  input  wire logic        outputZeroSwitch,
  input  wire logic [11:0] magnitude,
  input  wire logic        negative,
  output logic             comparatorOut
);
  timeunit 1ns;
  timeprecision 1ps;
  int integ = 0;

  // Charge per clock: reading while integrating, 1000 while returning,
  // so a wrong reference polarity runs away into overrange
  always @(posedge clk) begin
    if (signalSwitch)
      integ <= integ + (negative ? -int'(magnitude) : int'(magnitude));
    else if (referenceSwitch)
      integ <= integ + (referencePositive ? 1000 : -1000);
    else if (outputZeroSwitch)
      integ <= 0;
  end

  // High while the integrator sits on the negative side
  assign comparatorOut = integ < 0;
endmodule : frontend_model

//--- testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SEG [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                      7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        holdIn = 1'b0;
  logic        forceIn = 1'b0;
  logic [11:0] mag = 12'h000;
  logic        neg = 1'b0;
  logic        cmp, azS, sigS, refS, refPos, zeroS, pair, signSeg, plane;
  logic [6:0]  units, tens, hunds;
  int          errors = 0;
  int          nChecks = 0;
  int          cycles = 0;

  dual_slope_display_sequencer i_dut (
    .clk(clk), .rstn(rstn), .comparatorOut(cmp),
    .hold_reading_input(holdIn), .all_segments_force(forceIn),
    .autoZeroSwitch(azS), .signalSwitch(sigS), .referenceSwitch(refS),
    .referencePositive(refPos), .outputZeroSwitch(zeroS),
    .unitsSeg(units), .tensSeg(tens), .hundredsSeg(hunds),
    .thousands_one_pair(pair), .sign_segment_drive(signSeg),
    .common_plane_drive(plane)
  );
  frontend_model i_front (
    .clk(clk), .signalSwitch(sigS), .referenceSwitch(refS),
    .referencePositive(refPos), .outputZeroSwitch(zeroS),
    .magnitude(mag), .negative(neg), .comparatorOut(cmp)
  );

  initial forever #2 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Hung run counts as a mismatch; whole run is about 75000 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      report_and_stop();
    end
  end

  // Run one conversion of the given input, back in auto zero at the end
  task automatic convert(input logic [11:0] m, input logic n);
    int i;
    mag = m;
    neg = n;
    for (i = 0; i < 20000 && !sigS; i++) @(posedge clk);
    for (i = 0; i < 20000 && !azS; i++) @(posedge clk);
    #1;
  endtask : convert

  // Judge the lit pattern 8 clocks after each of two plane changes
  task automatic show(input int r, input logic one, mns, ovr);
    logic p;
    repeat (2) begin
      p = plane;
      while (plane === p) @(posedge clk);
      repeat (8) @(posedge clk);
      #1;
      check("units", units ^ {7{plane}}, ovr ? 7'h0 : SEG[r % 10]);
      check("tens", tens ^ {7{plane}}, ovr ? 7'h0 : SEG[r / 10 % 10]);
      check("hunds", hunds ^ {7{plane}}, ovr ? 7'h0 : SEG[r / 100 % 10]);
      check("pair", pair ^ plane, one);
      check("sign", signSeg ^ plane, mns);
    end
  endtask : show

  task automatic t_reset;
    check("az in reset", azS, 1'b1);
    check("sig in reset", sigS, 1'b0);
  endtask : t_reset

  task automatic t_hold;
    holdIn = 1'b1;
    convert(12'd42, 1'b0);
    show(1567, 1'b1, 1'b1, 1'b0);
    holdIn = 1'b0;
  endtask : t_hold

  // Forced pins stay static while the plane keeps running
  task automatic t_force;
    logic p;
    forceIn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    p = plane;
    check("forced", {units, tens, hunds, pair, signSeg}, 23'h7fffff);
    // Exactly one half period, so the plane has toggled exactly once
    repeat (400) @(posedge clk);
    #1;
    check("forced late", {units, tens, hunds, pair, signSeg}, 23'h7fffff);
    check("plane runs", plane !== p, 1'b1);
    forceIn = 1'b0;
  endtask : t_force

  initial begin
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    rstn = 1'b1;
    convert(12'd123, 1'b0);
    show(123, 1'b0, 1'b0, 1'b0);
    convert(12'd1567, 1'b1);
    show(1567, 1'b1, 1'b1, 1'b0);
    t_hold();
    convert(12'd2500, 1'b0);
    show(0, 1'b1, 1'b0, 1'b1);
    t_force();
    report_and_stop();
  end
endmodule : tb_top
